// [assc_pkg.sv]
/*
 * Package for the auxiliary converter sequencer step configuration bank:
 * register offsets, field positions, reset values and source codes.
 * Assumes a byte-wide register address and 16-bit register data.
 */
package assc_pkg;
	localparam int             ADDR_W       = 8;
	localparam int             DATA_W       = 16;
	localparam logic [7:0]     ADDR_SLOT11  = 8'h9B;
	localparam logic [7:0]     ADDR_SLOT12  = 8'h9C;
	localparam logic [15:0]    RST_SLOT11   = 16'h000B;
	localparam logic [15:0]    RST_SLOT12   = 16'h000C;
	localparam int             BIT_INCLUDE  = 15;
	localparam int             GAIN_HI      = 14;
	localparam int             GAIN_LO      = 13;
	localparam int             BIT_NEG      = 4;
	localparam int             POS_HI       = 3;
	localparam int             POS_LO       = 0;
	localparam logic [15:0]    WRITE_MASK   = 16'hE01F;
	// Positive-input codes that pick internal sources
	localparam logic [3:0]     POS_TEMP     = 4'h8;
	localparam logic [3:0]     POS_SHORT    = 4'h9;
	localparam logic [3:0]     POS_TESTDAC  = 4'hA;
	localparam logic [3:0]     POS_ASUPPLY  = 4'hB;
	localparam logic [3:0]     POS_IOSUPPLY = 4'hC;
	localparam logic [3:0]     POS_DSUPPLY  = 4'hD;
	localparam logic [3:0]     POS_ARAIL    = 4'hE;
	localparam logic [3:0]     POS_DRAIL    = 4'hF;
	// Gain factor encodings driven to the converter
	localparam logic [2:0]     GAIN_X1      = 3'h1;
	localparam logic [2:0]     GAIN_X2      = 3'h2;
	localparam logic [2:0]     GAIN_X4      = 3'h4;
	// Negative-input route encodings
	localparam logic [1:0]     NEG_GROUND   = 2'h0;
	localparam logic [1:0]     NEG_INSEVEN  = 2'h1;
	localparam logic [1:0]     NEG_AUTO     = 2'h2;
endpackage

// [assc_step_config.sv]
/*
 * Step configuration bank for the auxiliary multiplexed converter sequencer:
 * slot eleven setup register with decoded routing, and the slot twelve
 * setup register. Assumes a simple register port driven synchronously to
 * clk, one strobe per cycle, read data valid the cycle after the read.
 */
// Chosen here: strobed register access.
// Functional notes
// - Bit 15 includes or skips this step
// - Gain field: 00 x1, 01 x2, else x4
// - Negative select: 0 ground, 1 input seven
// - Codes 0-7 pick external inputs zero-seven
// - Codes 8-15 pick internal sources, auto negative
// - Internal sources ignore the negative select bit
// - Slot twelve at 9Ch, reset 000Ch
// - Slot eleven at 9Bh, reset 000Bh
module assc_step_config
	import assc_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [DATA_W-1:0] regWdata,
	input  wire logic              regWrite,
	input  wire logic              regRead,
	output logic      [DATA_W-1:0] regRdata,
	output logic                   slotInclude,
	output logic      [2:0]        slotGainFactor,
	output logic      [1:0]        slotNegRoute,
	output logic                   slotPosExternal,
	output logic      [2:0]        slotExtChannel,
	output logic      [3:0]        slotPosInputSelect,
	output logic      [DATA_W-1:0] slotTwelveSetup
);

	logic [DATA_W-1:0] slotElevenSetup_r;
	logic [DATA_W-1:0] slotElevenSetup_nxt;
	logic [DATA_W-1:0] slotTwelveSetup_r;
	logic [DATA_W-1:0] slotTwelveSetup_nxt;
	logic [DATA_W-1:0] regRdata_r;
	logic [DATA_W-1:0] regRdata_nxt;
	logic [1:0]        slotGainSelect;
	logic              slotNegInputSelect;

	// Register write path and read capture
	always_comb begin
		slotElevenSetup_nxt = slotElevenSetup_r;
		slotTwelveSetup_nxt = slotTwelveSetup_r;
		regRdata_nxt        = '0;
		if (regWrite && regAddr == ADDR_SLOT11) begin
			// Reserved bits never store, so they always read zero
			slotElevenSetup_nxt = regWdata & WRITE_MASK;
		end
		if (regWrite && regAddr == ADDR_SLOT12) begin
			slotTwelveSetup_nxt = regWdata & WRITE_MASK;
		end
		if (regRead) begin
			unique case (regAddr)
				ADDR_SLOT11: regRdata_nxt = slotElevenSetup_r;
				ADDR_SLOT12: regRdata_nxt = slotTwelveSetup_r;
				default:     regRdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			slotElevenSetup_r <= RST_SLOT11;
			slotTwelveSetup_r <= RST_SLOT12;
			regRdata_r        <= '0;
		end else begin
			slotElevenSetup_r <= slotElevenSetup_nxt;
			slotTwelveSetup_r <= slotTwelveSetup_nxt;
			regRdata_r        <= regRdata_nxt;
		end
	end

	assign regRdata        = regRdata_r;
	assign slotTwelveSetup = slotTwelveSetup_r;

	// Field decode for the sequencer and analog mux
	assign slotInclude        = slotElevenSetup_r[BIT_INCLUDE];
	assign slotGainSelect     = slotElevenSetup_r[GAIN_HI:GAIN_LO];
	assign slotNegInputSelect = slotElevenSetup_r[BIT_NEG];
	assign slotPosInputSelect = slotElevenSetup_r[POS_HI:POS_LO];

	always_comb begin
		unique case (slotGainSelect)
			2'h0:    slotGainFactor = GAIN_X1;
			2'h1:    slotGainFactor = GAIN_X2;
			2'h2, 2'h3: slotGainFactor = GAIN_X4;
		endcase
	end

	// Top bit of the code marks an internal source
	assign slotPosExternal = ~slotPosInputSelect[3];
	assign slotExtChannel  = slotPosInputSelect[2:0];

	always_comb begin
		if (!slotPosExternal) begin
			// Internal source picks its own return path
			slotNegRoute = NEG_AUTO;
		end else if (slotNegInputSelect) begin
			slotNegRoute = NEG_INSEVEN;
		end else begin
			slotNegRoute = NEG_GROUND;
		end
	end

	// Checks on the register port
	a_reserved_zero: assert property (
		@(posedge clk) disable iff (!nrst)
		regRdata[12:5] == 8'h00)
		else $error("reserved bits read nonzero");

	a_elev_readback: assert property (
		@(posedge clk) disable iff (!nrst)
		regRead && regAddr == ADDR_SLOT11
		|=> regRdata == $past(slotElevenSetup_r))
		else $error("slot eleven readback wrong");

	a_twelve_readback: assert property (
		@(posedge clk) disable iff (!nrst)
		regRead && regAddr == ADDR_SLOT12
		|=> regRdata == $past(slotTwelveSetup_r))
		else $error("slot twelve readback wrong");

	a_read_after_write: assert property (
		@(posedge clk) disable iff (!nrst)
		(regWrite && regAddr == ADDR_SLOT11)
		##1 (regRead && regAddr == ADDR_SLOT11)
		|=> regRdata == ($past(regWdata, 2) & WRITE_MASK))
		else $error("slot eleven read after write stale");

	a_twelve_fresh_read: assert property (
		@(posedge clk) disable iff (!nrst)
		(regWrite && regAddr == ADDR_SLOT12)
		##1 (regRead && regAddr == ADDR_SLOT12)
		|=> regRdata == ($past(regWdata, 2) & WRITE_MASK))
		else $error("slot twelve read after write stale");

	a_rdata_idle: assert property (
		@(posedge clk) disable iff (!nrst)
		!regRead |=> regRdata == 16'h0000)
		else $error("read data not cleared");

	a_unmapped_read: assert property (
		@(posedge clk) disable iff (!nrst)
		regRead && regAddr != ADDR_SLOT11 && regAddr != ADDR_SLOT12
		|=> regRdata == 16'h0000)
		else $error("unmapped read not zero");

	a_unmapped_write: assert property (
		@(posedge clk) disable iff (!nrst)
		regWrite && regAddr != ADDR_SLOT11 && regAddr != ADDR_SLOT12
		|=> $stable(slotElevenSetup_r) && $stable(slotTwelveSetup_r))
		else $error("unmapped write stored");

	// Reset checks carry no disable, they watch the reset itself
	a_rdata_reset: assert property (
		@(posedge clk)
		!nrst |=> regRdata == 16'h0000)
		else $error("read data not reset");

	// Checks on the stored words
	a_eleven_write: assert property (
		@(posedge clk) disable iff (!nrst)
		regWrite && regAddr == ADDR_SLOT11
		|=> slotElevenSetup_r == ($past(regWdata) & WRITE_MASK))
		else $error("slot eleven write lost");

	a_twelve_write: assert property (
		@(posedge clk) disable iff (!nrst)
		regWrite && regAddr == ADDR_SLOT12
		|=> slotTwelveSetup == ($past(regWdata) & WRITE_MASK))
		else $error("slot twelve write lost");

	a_eleven_hold: assert property (
		@(posedge clk) disable iff (!nrst)
		!(regWrite && regAddr == ADDR_SLOT11)
		|=> $stable(slotElevenSetup_r))
		else $error("slot eleven changed without a write");

	a_twelve_hold: assert property (
		@(posedge clk) disable iff (!nrst)
		!(regWrite && regAddr == ADDR_SLOT12)
		|=> $stable(slotTwelveSetup_r))
		else $error("slot twelve changed without a write");

	a_eleven_reserved: assert property (
		@(posedge clk) disable iff (!nrst)
		slotElevenSetup_r[12:5] == 8'h00)
		else $error("slot eleven reserved bits set");

	a_twelve_reserved: assert property (
		@(posedge clk) disable iff (!nrst)
		slotTwelveSetup_r[12:5] == 8'h00)
		else $error("slot twelve reserved bits set");

	a_reset_value: assert property (
		@(posedge clk)
		!nrst |=> slotElevenSetup_r == RST_SLOT11
		&& slotTwelveSetup_r == RST_SLOT12)
		else $error("reset values wrong");

	// Checks on the decoded step settings
	a_include_write: assert property (
		@(posedge clk) disable iff (!nrst)
		regWrite && regAddr == ADDR_SLOT11
		|=> slotInclude == $past(regWdata[15]))
		else $error("include bit not applied");

	a_gain_one: assert property (
		@(posedge clk) disable iff (!nrst)
		regWrite && regAddr == ADDR_SLOT11
		&& regWdata[14:13] == 2'h0
		|=> slotGainFactor == GAIN_X1)
		else $error("gain one decode wrong");

	a_gain_two: assert property (
		@(posedge clk) disable iff (!nrst)
		regWrite && regAddr == ADDR_SLOT11
		&& regWdata[14:13] == 2'h1
		|=> slotGainFactor == GAIN_X2)
		else $error("gain two decode wrong");

	a_gain_map: assert property (
		@(posedge clk) disable iff (!nrst)
		regWrite && regAddr == ADDR_SLOT11
		&& regWdata[14]
		|=> slotGainFactor == GAIN_X4)
		else $error("gain four decode wrong");

	a_gain_range: assert property (
		@(posedge clk) disable iff (!nrst)
		slotGainFactor == GAIN_X1 || slotGainFactor == GAIN_X2
		|| slotGainFactor == GAIN_X4)
		else $error("gain factor out of range");

	a_neg_manual: assert property (
		@(posedge clk) disable iff (!nrst)
		regWrite && regAddr == ADDR_SLOT11 && !regWdata[3]
		|=> slotNegRoute == {1'b0, $past(regWdata[4])})
		else $error("negative route wrong");

	a_ext_channel: assert property (
		@(posedge clk) disable iff (!nrst)
		regWrite && regAddr == ADDR_SLOT11 && !regWdata[3]
		|=> slotPosExternal && slotExtChannel == $past(regWdata[2:0]))
		else $error("external channel wrong");

	a_pos_raw: assert property (
		@(posedge clk) disable iff (!nrst)
		regWrite && regAddr == ADDR_SLOT11
		|=> slotPosInputSelect == $past(regWdata[3:0]))
		else $error("positive code not applied");

	a_internal_auto: assert property (
		@(posedge clk) disable iff (!nrst)
		regWrite && regAddr == ADDR_SLOT11 && regWdata[3]
		|=> !slotPosExternal && slotNegRoute == NEG_AUTO)
		else $error("internal source not auto");

	a_neg_ignored: assert property (
		@(posedge clk) disable iff (!nrst)
		regWrite && regAddr == ADDR_SLOT11
		&& regWdata[3] && regWdata[4]
		|=> slotNegRoute == NEG_AUTO)
		else $error("negative select not ignored");

	a_decode_internal: assert property (
		@(posedge clk) disable iff (!nrst)
		!slotPosExternal |-> slotNegRoute == NEG_AUTO)
		else $error("internal source without auto route");

	a_decode_external: assert property (
		@(posedge clk) disable iff (!nrst)
		slotPosExternal |-> slotNegRoute != NEG_AUTO)
		else $error("external source with auto route");

	// Main scenarios
	c_internal_src: cover property (@(posedge clk) disable iff (!nrst)
		!slotPosExternal && slotInclude);

	c_gain_four: cover property (@(posedge clk) disable iff (!nrst)
		slotGainFactor == GAIN_X4);

	c_neg_seven: cover property (@(posedge clk) disable iff (!nrst)
		slotNegRoute == NEG_INSEVEN);

	c_back_to_back: cover property (@(posedge clk) disable iff (!nrst)
		regWrite ##1 regRead);

	c_write_then_read: cover property (@(posedge clk) disable iff (!nrst)
		(regWrite && regAddr == ADDR_SLOT11)
		##1 (regRead && regAddr == ADDR_SLOT11));

endmodule // assc_step_config

// [assc_step_config_test.sv]
/* Self-checking bench for the sequencer step configuration bank.
   Assumes assc_pkg and assc_step_config are compiled before it. */
module assc_step_config_test
	import assc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic              clk = 1'b0;
	logic              nrst = 1'b0;
	logic [ADDR_W-1:0] regAddr = '0;
	logic [DATA_W-1:0] regWdata = '0;
	logic              regWrite = 1'b0;
	logic              regRead = 1'b0;
	logic [DATA_W-1:0] regRdata, slotTwelveSetup, d, e;
	logic              slotInclude, slotPosExternal;
	logic [2:0]        slotGainFactor, slotExtChannel;
	logic [1:0]        slotNegRoute;
	logic [3:0]        slotPosInputSelect;
	int                err_total = 0;
	int                total_checks = 0;
	always #4 clk = ~clk;
	assc_step_config dut_u (.clk(clk), .nrst(nrst), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata(regRdata), .slotInclude(slotInclude),
		.slotGainFactor(slotGainFactor), .slotNegRoute(slotNegRoute),
		.slotPosExternal(slotPosExternal), .slotExtChannel(slotExtChannel),
		.slotPosInputSelect(slotPosInputSelect),
		.slotTwelveSetup(slotTwelveSetup));
	function automatic logic [2:0] expGain(logic [15:0] v);
		return (v[14:13] == 2'h0) ? GAIN_X1 :
			(v[14:13] == 2'h1) ? GAIN_X2 : GAIN_X4;
	endfunction
	function automatic logic [1:0] expNeg(logic [15:0] v);
		return v[3] ? NEG_AUTO : (v[4] ? NEG_INSEVEN : NEG_GROUND);
	endfunction
	task automatic chk(logic [15:0] got, logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chkSlot(logic [15:0] v);
		chk(slotInclude, v[15]);
		chk(slotGainFactor, expGain(v));
		chk(slotNegRoute, expNeg(v));
		chk(slotPosExternal, !v[3]);
		chk(slotExtChannel, v[2:0]);
		chk(slotPosInputSelect, v[3:0]);
	endtask
	task automatic wr(logic [7:0] a, logic [15:0] v);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= v;
		@(posedge clk);
		regWrite <= 1'b0;
		regWdata <= 16'hFFFF;
		@(negedge clk);
	endtask
	task automatic rd(logic [7:0] a, logic [15:0] v);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		@(negedge clk);
		chk(regRdata, v);
		@(negedge clk);
		chk(regRdata, 16'h0000);
	endtask
	// Write strobe followed at once by a read of the same word
	task automatic wrRd(logic [7:0] a, logic [15:0] v);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= v;
		@(posedge clk);
		regWrite <= 1'b0;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		@(negedge clk);
		chk(regRdata, v & WRITE_MASK);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#100000;
		err_total++;
		report_and_stop();
	end
	initial begin
		void'($urandom(32'h1919));
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		chkSlot(RST_SLOT11);
		chk(slotTwelveSetup, RST_SLOT12);
		rd(ADDR_SLOT11, RST_SLOT11);
		rd(ADDR_SLOT12, RST_SLOT12);
		// Walk every gain, negative and positive code with random filler
		for (int i = 0; i < 128; i++) begin
			d = 16'($urandom);
			d[4:0] = i[4:0];
			d[14:13] = i[6:5];
			e = 16'($urandom);
			wr(ADDR_SLOT11, d);
			wr(ADDR_SLOT12, e);
			chkSlot(d);
			chk(slotTwelveSetup, e & WRITE_MASK);
			rd(ADDR_SLOT11, d & WRITE_MASK);
			rd(ADDR_SLOT12, e & WRITE_MASK);
		end
		// Neighbouring unmapped addresses must neither store nor answer
		wr(8'h9D, 16'hFFFF);
		wr(8'h9A, 16'hFFFF);
		rd(8'h9D, 16'h0000);
		rd(8'h9A, 16'h0000);
		chkSlot(d);
		chk(slotTwelveSetup, e & WRITE_MASK);
		// No gap between write and read: corner words, then a random one
		wrRd(ADDR_SLOT11, 16'hFFFF);
		chkSlot(16'hFFFF);
		wrRd(ADDR_SLOT12, 16'h0000);
		chk(slotTwelveSetup, 16'h0000);
		d = 16'($urandom);
		wrRd(ADDR_SLOT11, d);
		chkSlot(d);
		// A reset in mid-run must restore both slots
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		chkSlot(RST_SLOT11);
		chk(slotTwelveSetup, RST_SLOT12);
		rd(ADDR_SLOT12, RST_SLOT12);
		report_and_stop();
	end
endmodule // assc_step_config_test
